// [hdl/nms_pkg.sv]
// constants, field layouts and state codes shared by the memory scanner files
package nms_pkg;

	// ==========================================================
	// register byte offsets on the bus
	localparam logic [7:0] OFF_CONTROL   = 8'h00;
	localparam logic [7:0] OFF_CUR_LOW   = 8'h04;
	localparam logic [7:0] OFF_CUR_HIGH  = 8'h08;
	localparam logic [7:0] OFF_END_LOW   = 8'h0C;
	localparam logic [7:0] OFF_END_HIGH  = 8'h10;
	localparam logic [7:0] OFF_TRIG_SEL  = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h1C;

	// ==========================================================
	// control register field positions
	localparam int CTL_EN     = 7;
	localparam int CTL_RUN    = 6;
	localparam int CTL_BUSY   = 5;
	localparam int CTL_INVAL  = 4;
	localparam int CTL_INTM   = 3;
	localparam int CTL_MODE_H = 1;
	localparam int CTL_MODE_L = 0;

	// interrupt status bit positions
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_INVAL = 1;

	// ==========================================================
	// reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_ADDR  = 16'h0000;
	localparam logic [3:0]  RST_TRIGGER_SOURCE_SELECT  = 4'h0;
	localparam logic [1:0]  RST_MODE  = 2'h0;
	localparam logic [1:0]  RST_IRQ   = 2'h0;

	// ==========================================================
	// access modes
	localparam logic [1:0] MODE_CONCURRENT = 2'h0;
	localparam logic [1:0] MODE_BURST      = 2'h1;
	localparam logic [1:0] MODE_PEEK       = 2'h2;
	localparam logic [1:0] MODE_TRIGGERED  = 2'h3;

	// trigger sources, one input bit per source in select order
	localparam int          TRIG_COUNT    = 10;
	localparam logic [3:0]  TRIGGER_SOURCE_SELECT_LAST_OK  = 4'h9;

	// ==========================================================
	// scanner sequencer states, one-hot
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_HOLD  = 3'b100
	} nms_state_e;

endpackage : nms_pkg

// [hdl/nms_scanner.sv]
// memory scanner: walks program memory from current to final address feeding a crc engine
// Notes on behaviour
// - current address is sixteen bits, two bytes
// - each fetch bumps the current address by one
// - address writes dropped while run request set
// - final address is sixteen bits, two bytes
// - four-bit select picks trigger pacing source
// - hardware clears run request past final address
// - invalid flag when past end or nonexistent
// - fetch only after crc ready, then hand over
// - two-bit mode: triggered, peek, burst, concurrent
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module nms_scanner
#(
	parameter logic [16:0] MEM_WORDS = 17'h04000
)
(
	input  wire logic                           i_mclk,
	input  wire logic                           i_reset,
	// ahb-lite slave
	input  wire logic                           i_hsel,
	input  wire logic [31:0]                    i_haddr,
	input  wire logic [1:0]                     i_htrans,
	input  wire logic                           i_hwrite,
	input  wire logic [2:0]                     i_hsize,
	input  wire logic [31:0]                    i_hwdata,
	input  wire logic                           i_hready,
	output logic      [31:0]                    o_hrdata,
	output logic                                o_hreadyout,
	output logic                                o_hresp,
	// program memory read port
	output logic                                o_mem_req,
	output logic      [15:0]                    o_mem_addr,
	input  wire logic                           i_mem_ack,
	input  wire logic [15:0]                    i_mem_rdata,
	// crc engine side
	input  wire logic                           i_crc_ready,
	output logic                                o_crc_valid,
	output logic      [15:0]                    o_crc_data,
	// cpu side
	input  wire logic                           i_cpu_idle,
	input  wire logic                           i_int_active,
	output logic                                o_cpu_stall,
	// trigger sources and interrupt
	input  wire logic [nms_pkg::TRIG_COUNT-1:0] i_trig_src,
	output logic                                o_irq
);

	// ==========================================================
	// declarations
	logic                 en_q;
	logic                 run_q;
	logic                 intm_q;
	logic [1:0]           mode_q;
	logic [15:0]          cur_q;
	logic [15:0]          end_q;
	logic [3:0]           trigger_source_select_q;
	logic [1:0]           irq_stat_q;
	logic [1:0]           irq_mask_q;
	logic                 wr_pend_q;
	logic                 rd_wait_q;
	logic [7:0]           dph_addr_q;
	logic [31:0]          hrdata_q;
	logic [7:0]           rd_byte_d;
	nms_trig_if           trig ();
	nms_pkg::nms_state_e  state_q;
	logic                 trig_pend_q;
	logic                 crc_valid_q;
	logic [15:0]          crc_data_q;
	logic                 past_end;
	logic                 oob;
	logic                 invalid;
	logic                 run_eff;
	logic                 mode_ok;
	logic                 start_fetch;
	logic                 hw_stop;
	logic                 busy;
	logic                 addr_phase;
	logic                 wr_ctl;
	logic                 wr_cur_l;
	logic                 wr_cur_h;
	logic                 wr_end_l;
	logic                 wr_end_h;
	logic                 wr_trigger_source_select;
	logic                 wr_stat;
	logic                 wr_mask;
	logic [7:0]           wbyte;

	// ==========================================================
	// bus decode
	// accept a transfer only when the bus is ready and we are selected
	assign addr_phase = i_hsel & i_htrans[1] & i_hready;
	assign wbyte      = i_hwdata[7:0];

	// write strobes, valid in the data phase of a write
	assign wr_ctl   = wr_pend_q & (dph_addr_q == nms_pkg::OFF_CONTROL);
	assign wr_cur_l = wr_pend_q & (dph_addr_q == nms_pkg::OFF_CUR_LOW);
	assign wr_cur_h = wr_pend_q & (dph_addr_q == nms_pkg::OFF_CUR_HIGH);
	assign wr_end_l = wr_pend_q & (dph_addr_q == nms_pkg::OFF_END_LOW);
	assign wr_end_h = wr_pend_q & (dph_addr_q == nms_pkg::OFF_END_HIGH);
	assign wr_trigger_source_select  = wr_pend_q & (dph_addr_q == nms_pkg::OFF_TRIG_SEL);
	assign wr_stat  = wr_pend_q & (dph_addr_q == nms_pkg::OFF_IRQ_STAT);
	assign wr_mask  = wr_pend_q & (dph_addr_q == nms_pkg::OFF_IRQ_MASK);

	// latch the address phase; reads get one wait state so data is registered
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_pend_q  <= 1'b0;
			rd_wait_q  <= 1'b0;
			dph_addr_q <= nms_pkg::RST_BYTE;
		end
		else
		begin
			wr_pend_q <= addr_phase & i_hwrite;
			rd_wait_q <= addr_phase & ~i_hwrite;
			if (addr_phase)
				dph_addr_q <= {i_haddr[7:2], 2'b00};
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb
	begin
		if (dph_addr_q == nms_pkg::OFF_CONTROL)
			rd_byte_d = {en_q, run_q, busy, invalid, intm_q, 1'b0, mode_q};
		else if (dph_addr_q == nms_pkg::OFF_CUR_LOW)
			rd_byte_d = cur_q[7:0];
		else if (dph_addr_q == nms_pkg::OFF_CUR_HIGH)
			rd_byte_d = cur_q[15:8];
		else if (dph_addr_q == nms_pkg::OFF_END_LOW)
			rd_byte_d = end_q[7:0];
		else if (dph_addr_q == nms_pkg::OFF_END_HIGH)
			rd_byte_d = end_q[15:8];
		else if (dph_addr_q == nms_pkg::OFF_TRIG_SEL)
			rd_byte_d = {4'h0, trigger_source_select_q};
		else if (dph_addr_q == nms_pkg::OFF_IRQ_STAT)
			rd_byte_d = {6'h00, irq_stat_q};
		else if (dph_addr_q == nms_pkg::OFF_IRQ_MASK)
			rd_byte_d = {6'h00, irq_mask_q};
		else
			rd_byte_d = 8'h00;
	end

	// read data register, loaded in the wait cycle
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			hrdata_q <= 32'h00000000;
		else if (rd_wait_q)
			hrdata_q <= {24'h000000, rd_byte_d};
	end

	assign o_hrdata    = hrdata_q;
	assign o_hreadyout = ~rd_wait_q;
	assign o_hresp     = 1'b0;

	// ==========================================================
	// control register
	// software write wins over a hardware stop in the same cycle
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			en_q   <= 1'b0;
			run_q  <= 1'b0;
			intm_q <= 1'b0;
			mode_q <= nms_pkg::RST_MODE;
		end
		else if (wr_ctl)
		begin
			en_q   <= wbyte[nms_pkg::CTL_EN];
			run_q  <= wbyte[nms_pkg::CTL_RUN];
			intm_q <= wbyte[nms_pkg::CTL_INTM];
			mode_q <= wbyte[nms_pkg::CTL_MODE_H:nms_pkg::CTL_MODE_L];
		end
		else if (hw_stop)
			run_q <= 1'b0;
	end

	// ==========================================================
	// address registers
	// current address, two bytes; bump on fetch
	// the increment wins over a write; a fetch can still end after software clears run
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			cur_q <= nms_pkg::RST_ADDR;
		else if (state_q == nms_pkg::ST_FETCH && i_mem_ack)
			cur_q <= cur_q + 16'h0001;
		else if (!run_q && wr_cur_l)
			cur_q[7:0] <= wbyte;
		else if (!run_q && wr_cur_h)
			cur_q[15:8] <= wbyte;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			end_q <= nms_pkg::RST_ADDR;
		else if (!run_q && wr_end_l)
			end_q[7:0] <= wbyte;
		else if (!run_q && wr_end_h)
			end_q[15:8] <= wbyte;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			trigger_source_select_q <= nms_pkg::RST_TRIGGER_SOURCE_SELECT;
		else if (wr_trigger_source_select)
			trigger_source_select_q <= wbyte[3:0];
	end

	assign trig.sel = trigger_source_select_q;

	// ==========================================================
	// trigger picking lives in its own module
	nms_trig_pick u_trig_pick
	(
		.i_mclk     (i_mclk),
		.i_reset    (i_reset),
		.i_trig_src (i_trig_src),
		.trig       (trig.picker)
	);

	// ==========================================================
	// scan qualifiers
	// invalid when past the end or beyond the memory
	assign past_end = cur_q > end_q;
	assign oob      = {1'b0, cur_q} >= MEM_WORDS;
	assign invalid  = past_end | oob;

	// interrupt override masks the run request outside peek mode, without clearing it
	assign run_eff = en_q & run_q & ~(intm_q & i_int_active & (mode_q != nms_pkg::MODE_PEEK));

	// per-mode permission to start a fetch
	always_comb
	begin
		case (mode_q)
			nms_pkg::MODE_PEEK:      mode_ok = i_cpu_idle;
			nms_pkg::MODE_TRIGGERED: mode_ok = trig_pend_q;
			default:                 mode_ok = 1'b1;
		endcase
	end

	// start only with the crc engine ready
	assign start_fetch = (state_q == nms_pkg::ST_IDLE) & run_eff & ~invalid & mode_ok & i_crc_ready;

	// stop when idle and out of range; a cycle in flight finishes first
	assign hw_stop = en_q & run_q & (state_q == nms_pkg::ST_IDLE) & invalid;

	assign busy = (state_q != nms_pkg::ST_IDLE) | (run_eff & i_crc_ready);

	assign o_cpu_stall = en_q & run_q & (mode_q == nms_pkg::MODE_BURST);

	// ==========================================================
	// trigger pending flag
	// one pending event at most; a start consumes it
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			trig_pend_q <= 1'b0;
		else if (!en_q || mode_q != nms_pkg::MODE_TRIGGERED || !run_q)
			trig_pend_q <= 1'b0;
		else if (trig.event_pulse)
			trig_pend_q <= 1'b1;
		else if (start_fetch)
			trig_pend_q <= 1'b0;
	end

	// ==========================================================
	// fetch sequencer; disabling resets it, registers keep their values
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			state_q <= nms_pkg::ST_IDLE;
		else if (!en_q)
			state_q <= nms_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				nms_pkg::ST_IDLE:
					if (start_fetch)
						state_q <= nms_pkg::ST_FETCH;
				nms_pkg::ST_FETCH:
					if (i_mem_ack)
						state_q <= nms_pkg::ST_HOLD;
				// one spare cycle lets the crc drop ready before the next decision
				nms_pkg::ST_HOLD:
					state_q <= nms_pkg::ST_IDLE;
				default:
					state_q <= nms_pkg::ST_IDLE;
			endcase
		end
	end

	assign o_mem_req  = state_q == nms_pkg::ST_FETCH;
	assign o_mem_addr = cur_q;

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			crc_valid_q <= 1'b0;
			crc_data_q  <= 16'h0000;
		end
		else
		begin
			crc_valid_q <= (state_q == nms_pkg::ST_FETCH) & i_mem_ack & en_q;
			if ((state_q == nms_pkg::ST_FETCH) && i_mem_ack)
				crc_data_q <= i_mem_rdata;
		end
	end

	assign o_crc_valid = crc_valid_q;
	assign o_crc_data  = crc_data_q;

	// ==========================================================
	// interrupt status, write one to clear; a new event wins over the clear
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			irq_stat_q <= nms_pkg::RST_IRQ;
		else
		begin
			irq_stat_q[nms_pkg::IRQ_DONE] <= hw_stop |
				(irq_stat_q[nms_pkg::IRQ_DONE] & ~(wr_stat & wbyte[nms_pkg::IRQ_DONE]));
			// flag raised only when a run stops on an address beyond memory
			irq_stat_q[nms_pkg::IRQ_INVAL] <= (hw_stop & oob) |
				(irq_stat_q[nms_pkg::IRQ_INVAL] & ~(wr_stat & wbyte[nms_pkg::IRQ_INVAL]));
		end
	end

	// interrupt mask
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			irq_mask_q <= nms_pkg::RST_IRQ;
		else if (wr_mask)
			irq_mask_q <= wbyte[1:0];
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule : nms_scanner

// [hdl/nms_trig_if.sv]
// carries the trigger select and the resulting event pulse between scanner modules
`timescale 1ns/1ps

interface nms_trig_if;
	logic [3:0] sel;
	logic       event_pulse;

	// trigger picker drives the pulse
	modport picker
	(
		input  sel,
		output event_pulse
	);

	// scanner core owns the select
	modport core
	(
		output sel,
		input  event_pulse
	);
endinterface : nms_trig_if

// [hdl/nms_trig_pick.sv]
// synchronises trigger sources, selects one and turns its rising edge into a pulse
`timescale 1ns/1ps

module nms_trig_pick
(
	input  wire logic                         i_mclk,
	input  wire logic                         i_reset,
	input  wire logic [nms_pkg::TRIG_COUNT-1:0] i_trig_src,
	nms_trig_if.picker                        trig
);

	logic [nms_pkg::TRIG_COUNT-1:0] meta_q;
	logic [nms_pkg::TRIG_COUNT-1:0] sync_q;
	logic                           pick_q;
	logic                           pick_d;

	// ==========================================================
	// two-stage sync; sources run on other clocks
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_trig_src;
			sync_q <= meta_q;
		end
	end

	// source select mux
	// reserved codes pick nothing, so they never pace a fetch
	always_comb
	begin
		if (trig.sel <= nms_pkg::TRIGGER_SOURCE_SELECT_LAST_OK)
			pick_d = sync_q[trig.sel];
		else
			pick_d = 1'b0;
	end

	// ==========================================================
	// edge detect on the synchronised, selected level
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			pick_q <= 1'b0;
		else
			pick_q <= pick_d;
	end

	assign trig.event_pulse = pick_d & ~pick_q;

endmodule : nms_trig_pick

// [verif/nms_crc_model.sv]
// behavioural program memory and crc engine on the scanner's far side
`timescale 1ns/1ps

module nms_crc_model
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_slow,
	input  wire logic        i_hold,
	input  wire logic        i_mem_req,
	input  wire logic [15:0] i_mem_addr,
	output logic             o_mem_ack,
	output logic      [15:0] o_mem_rdata,
	output logic             o_crc_ready,
	input  wire logic        i_crc_valid,
	input  wire logic [15:0] i_crc_data,
	output int               o_words,
	output logic      [15:0] o_last
);
	logic [1:0] wait_q;
	logic [1:0] busy_q;

	// memory acks after one or three cycles; data toggles off the ack cycle
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wait_q      <= 2'h0;
			o_mem_ack   <= 1'b0;
			o_mem_rdata <= 16'h0000;
		end
		else
		begin
			o_mem_ack   <= 1'b0;
			o_mem_rdata <= ~o_mem_rdata;
			if (i_mem_req && !o_mem_ack)
			begin
				wait_q <= wait_q + 2'h1;
				if (wait_q >= {i_slow, 1'b0})
				begin
					wait_q      <= 2'h0;
					o_mem_ack   <= 1'b1;
					o_mem_rdata <= i_mem_addr ^ 16'h5A3C;
				end
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			busy_q  <= 2'h0;
			o_words <= 0;
			o_last  <= 16'h0000;
		end
		else if (i_crc_valid)
		begin
			busy_q  <= {i_slow, i_slow};
			o_words <= o_words + 1;
			o_last  <= i_crc_data;
		end
		else if (busy_q != 2'h0)
			busy_q <= busy_q - 2'h1;
	end

	// slow engine stays busy three cycles per word
	assign o_crc_ready = !i_hold && busy_q == 2'h0;
endmodule : nms_crc_model

// [verif/nms_scanner_chk.sv]
// port-level assertions for the memory scanner
`timescale 1ns/1ps

module nms_scanner_chk
#(
	parameter logic [16:0] MEM_WORDS = 17'h04000
)
(
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic        i_hsel,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic        i_hready,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        o_mem_req,
	input wire logic [15:0] o_mem_addr,
	input wire logic        i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	input wire logic        i_crc_ready,
	input wire logic        o_crc_valid,
	input wire logic [15:0] o_crc_data
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	// ====
	// bus answers: always okay, one wait state per read
	a_resp_okay: assert property (!o_hresp)
		else $error("bus error response");
	a_read_wait: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait state wrong");

	// ====
	// fetch and hand-over
	a_ready_gate: assert property ($rose(o_mem_req) |-> $past(i_crc_ready))
		else $error("fetch without crc ready");
	a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("fetch dropped early");
	a_addr_step: assert property (o_mem_req && i_mem_ack |=> o_mem_addr == $past(o_mem_addr) + 16'h0001)
		else $error("address not stepped");
	a_word_pass: assert property (o_mem_req && i_mem_ack |=> o_crc_valid && o_crc_data == $past(i_mem_rdata))
		else $error("word not handed over");
	a_valid_gap: assert property (o_crc_valid |=> !o_crc_valid && !o_mem_req)
		else $error("valid not a single pulse");
	a_addr_range: assert property (o_mem_req |-> {1'b0, o_mem_addr} < MEM_WORDS)
		else $error("fetch of nonexistent word");
endmodule : nms_scanner_chk

bind nms_scanner nms_scanner_chk #(.MEM_WORDS(MEM_WORDS)) i_nms_scanner_chk
(
	.i_mclk, .i_reset, .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp, .o_mem_req,
	.o_mem_addr, .i_mem_ack, .i_mem_rdata, .i_crc_ready, .o_crc_valid, .o_crc_data
);

// [verif/nvm_memory_scanner_test.sv]
// self-checking bench for the memory scanner
`timescale 1ns/1ps

module nvm_memory_scanner_test;
	logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, idle = 0, slow = 0, hold = 0, intr = 0;
	logic        hrdy, hresp, mreq, mack, crdy, cval, stall, irq;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [15:0] maddr, mrdata, cdat, last;
	logic [9:0]  trig = 0;
	int          words, errors = 0, cmp_count = 0;

	// ====
	// clock, design and far side
	always #2.5 clk = ~clk;

	nms_scanner #(.MEM_WORDS(17'h00200)) i_nms_scanner
	(
		.i_mclk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
		.o_hresp(hresp), .o_mem_req(mreq), .o_mem_addr(maddr), .i_mem_ack(mack), .i_mem_rdata(mrdata),
		.i_crc_ready(crdy), .o_crc_valid(cval), .o_crc_data(cdat), .i_cpu_idle(idle), .i_int_active(intr),
		.o_cpu_stall(stall), .i_trig_src(trig), .o_irq(irq)
	);

	nms_crc_model i_nms_crc_model
	(
		.i_mclk(clk), .i_reset(rst), .i_slow(slow), .i_hold(hold), .i_mem_req(mreq), .i_mem_addr(maddr),
		.o_mem_ack(mack), .o_mem_rdata(mrdata), .o_crc_ready(crdy), .i_crc_valid(cval), .i_crc_data(cdat),
		.o_words(words), .o_last(last)
	);

	// ====
	// shared tasks
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// single word transfer; waits on hready, no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk iff hrdy);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk iff hrdy);
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rc(input string n, input logic [7:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(n, r, {24'h0, e});
	endtask : rc

	// poll until the run bit drops, bounded
	task automatic poll;
		logic [31:0] r;
		r = 32'h40;
		for (int i = 0; i < 60 && r[6]; i++)
			bus(1'b0, nms_pkg::OFF_CONTROL, 8'h00, r);
		// a poll that runs out counts against the run
		chk("run bit", {31'h0, r[6]}, 32'h0);
		repeat (2) @(posedge clk);
	endtask : poll

	task automatic pulse(input logic [9:0] m);
		trig <= m;
		repeat (4) @(posedge clk);
		trig <= 10'h000;
		repeat (10) @(posedge clk);
	endtask : pulse

	task automatic addr(input logic [7:0] cl, ch, el, eh);
		wr(nms_pkg::OFF_CUR_LOW, cl);
		wr(nms_pkg::OFF_CUR_HIGH, ch);
		wr(nms_pkg::OFF_END_LOW, el);
		wr(nms_pkg::OFF_END_HIGH, eh);
	endtask : addr

	// ====
	// scenarios
	task automatic t_regs;
		wr(8'h20, 8'h5A);
		for (int a = 0; a < 36; a += 4)
			rc("reset value", a[7:0], 8'h00);
		for (int a = 4; a < 20; a += 4)
		begin
			wr(a[7:0], 8'hA0 + a[7:0]);
			rc("address byte", a[7:0], 8'hA0 + a[7:0]);
		end
		wr(nms_pkg::OFF_TRIG_SEL, 8'hFF);
		rc("trigger select", nms_pkg::OFF_TRIG_SEL, 8'h0F);
	endtask : t_regs

	// slow far side, address writes in mid-run, masked then unmasked irq
	task automatic t_scan;
		int n;
		n = words;
		addr(8'h10, 8'h01, 8'h12, 8'h01);
		slow <= 1'b1;
		wr(nms_pkg::OFF_CONTROL, 8'hC0);
		wr(nms_pkg::OFF_CUR_LOW, 8'h77);
		wr(nms_pkg::OFF_END_HIGH, 8'h05);
		poll;
		slow <= 1'b0;
		chk("word count", words, n + 3);
		chk("last word", last, 16'h0112 ^ 16'h5A3C);
		rc("current low", nms_pkg::OFF_CUR_LOW, 8'h13);
		rc("end high", nms_pkg::OFF_END_HIGH, 8'h01);
		rc("control", nms_pkg::OFF_CONTROL, 8'h90);
		rc("status", nms_pkg::OFF_IRQ_STAT, 8'h01);
		chk("masked irq", irq, 1'b0);
		wr(nms_pkg::OFF_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b1);
		wr(nms_pkg::OFF_IRQ_STAT, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 1'b0);
	endtask : t_scan

	// scan runs off the end of memory
	task automatic t_inval;
		int n;
		n = words;
		addr(8'hFE, 8'h01, 8'h00, 8'h02);
		wr(nms_pkg::OFF_IRQ_MASK, 8'h03);
		wr(nms_pkg::OFF_CONTROL, 8'hC0);
		poll;
		chk("words to end", words, n + 2);
		rc("control", nms_pkg::OFF_CONTROL, 8'h90);
		rc("status", nms_pkg::OFF_IRQ_STAT, 8'h03);
		wr(nms_pkg::OFF_IRQ_STAT, 8'h03);
		rc("status cleared", nms_pkg::OFF_IRQ_STAT, 8'h00);
	endtask : t_inval

	// concurrent, burst, peek with crc held off, cpu busy and interrupt override
	task automatic t_modes;
		int n;
		for (int m = 0; m < 3; m++)
		begin
			addr(8'h3F, 8'h00, 8'h3F, 8'h00);
			hold <= 1'b1;
			idle <= 1'b0;
			intr <= 1'b1;
			n = words;
			wr(nms_pkg::OFF_CONTROL, 8'hC8 | m[7:0]);
			repeat (6) @(posedge clk);
			chk("stall", stall, m == 1);
			chk("held off", words, n);
			hold <= 1'b0;
			repeat (12) @(posedge clk);
			chk("irq override", words, n);
			intr <= 1'b0;
			repeat (12) @(posedge clk);
			chk("peek wait", words, n + (m != 2));
			idle <= 1'b1;
			poll;
			chk("mode fetch", words, n + 1);
		end
	endtask : t_modes

	// select codes 0 to 10: every source plus one reserved code
	task automatic t_trig;
		int n;
		addr(8'h20, 8'h00, 8'h2F, 8'h00);
		for (int k = 0; k < 11; k++)
		begin
			wr(nms_pkg::OFF_TRIG_SEL, k[7:0]);
			n = words;
			wr(nms_pkg::OFF_CONTROL, 8'hC3);
			pulse(~(10'h001 << k));
			chk("other source", words, n);
			pulse(10'h001 << k);
			chk("own source", words, n + (k < 10));
			wr(nms_pkg::OFF_CONTROL, 8'h80);
		end
	endtask : t_trig

	// ====
	// sequence, watchdog and verdict
	task automatic wrap_up;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_scan;
		t_inval;
		t_modes;
		t_trig;
		wrap_up;
	end

	// run needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
endmodule : nvm_memory_scanner_test
